// ==== hdl/umc_baud_meter.sv ====
// Bit period measurement over a 0x55 sync character.
// Assumes rx is synchronised, idle high, start bit low.
`timescale 1ns/1ps
module umc_baud_meter #(
  parameter int CW = 20
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          arm,
  input  wire logic          rx,
  output logic               done,
  output logic      [CW-1:0] period
);
  typedef struct packed {
    logic          busy;
    logic [2:0]    edges;
    logic [CW-1:0] cnt;
    logic          prev;
    logic          done;
    logic [CW-1:0] period;
  } umc_meter_t;

  umc_meter_t st_ff;
  umc_meter_t nxt_st;
  logic       fall;

  // First falling edge to fifth spans eight bit times
  always_comb
  begin
    nxt_st      = st_ff;
    fall        = st_ff.prev & ~rx;
    nxt_st.prev = rx;
    nxt_st.done = 1'b0;
    if (!arm)
    begin
      nxt_st.busy  = 1'b0;
      nxt_st.edges = 3'd0;
    end
    else if (!st_ff.busy)
    begin
      if (fall && !st_ff.done)
      begin
        nxt_st.busy  = 1'b1;
        nxt_st.edges = 3'd0;
        nxt_st.cnt   = CW'(1);
      end
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
      if (fall)
      begin
        nxt_st.edges = st_ff.edges + 3'd1;
        if (st_ff.edges + 3'd1 == umc_pkg::SYNC_EDGES)
        begin
          nxt_st.busy   = 1'b0;
          nxt_st.done   = 1'b1;
          nxt_st.period = st_ff.cnt >> umc_pkg::SYNC_BITS_LOG;
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= '{prev: 1'b1, default: '0};
    else
      st_ff <= nxt_st;
  end

  assign done   = st_ff.done;
  assign period = st_ff.period;
endmodule

// ==== hdl/umc_mode_ctrl.sv ====
// Mode and status control of an asynchronous serial transceiver.
// Assumes a transceiver core on ref_clk supplies tx bits, flags and ticks.
`timescale 1ns/1ps
module umc_mode_ctrl #(
  parameter int BAUD_W = 20
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        cpu_idle,
  input  wire logic        cpu_sleep,
  output logic             wake_req,
  input  wire logic        serial_in_pin,
  input  wire logic        clear_to_send_pin,
  output logic             serial_out_pin_o,
  output logic             serial_out_pin_oe,
  output logic             request_to_send_pin_o,
  output logic             request_to_send_pin_oe,
  output logic             baud_clock_out_pin_o,
  output logic             baud_clock_out_pin_oe,
  input  wire logic        baud_tick,
  input  wire logic        core_tx_bit,
  input  wire logic        core_rts_flow,
  input  wire logic        core_rts_simplex,
  input  wire logic        core_tx_buffer_full,
  input  wire logic        core_tx_shift_empty,
  input  wire logic        core_receiver_idle,
  input  wire logic        core_parity_error,
  input  wire logic        core_framing_error,
  input  wire logic        core_overrun,
  input  wire logic        core_rx_data_available,
  input  wire logic        core_break_done,
  output logic             core_run,
  output logic             core_rx_bit,
  output logic             core_cts_n,
  output logic             core_rx_flush,
  output logic             cfg_high_speed,
  output logic      [1:0]  cfg_format,
  output logic             cfg_two_stop,
  output logic      [31:0] cfg_status
);
  typedef struct packed {
    logic [31:0]                 mode;
    logic [31:0]                 sta;
    logic [umc_pkg::IRQ_W-1:0]   irq_st;
    logic [umc_pkg::IRQ_W-1:0]   irq_en;
    logic [BAUD_W-1:0]           baud;
    logic [31:0]                 rdata;
    logic                        tx_o;
    logic                        tx_oe;
    logic                        rts_o;
    logic                        rts_oe;
    logic                        bclk_o;
    logic                        bclk_oe;
    logic                        rx_bit;
    logic                        cts_n;
    logic                        run;
    logic                        wake;
    logic                        irq;
    logic                        flush;
    logic                        prev_rx;
    logic                        prev_tx;
    logic [4:0]                  enc_cnt;
    logic [4:0]                  dec_cnt;
  } umc_state_t;

  umc_state_t        st_ff;
  umc_state_t        nxt_st;
  logic [1:0]        pins_s;
  logic              rx_s;
  logic              cts_s;
  logic              meas_done;
  logic [BAUD_W-1:0] meas_period;
  logic              rx_lvl;

  // ------------------------------------------------------------
  // Pin synchronisers and baud measurement
  // ------------------------------------------------------------
  umc_sync #(
    .W (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({serial_in_pin, clear_to_send_pin}),
    .q       (pins_s)
  );

  assign rx_s  = pins_s[1];
  assign cts_s = pins_s[0];

  umc_baud_meter #(
    .CW (BAUD_W)
  ) u_meter (
    .ref_clk (ref_clk),
    .rst     (rst),
    .arm     (st_ff.mode[umc_pkg::M_AUTO_BAUD_ENABLE] & st_ff.run),
    .rx      (rx_lvl),
    .done    (meas_done),
    .period  (meas_period)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic             on;
    logic             run;
    logic             infrared_enable;
    logic             hs;
    logic [1:0]       op;
    logic [4:0]       ticks;
    logic [4:0]       pulse;
    logic             enc;
    logic             raw;
    logic             pulse_in;
    logic             dec;
    logic             overrun_error_old;
    logic             fall;
    umc_pkg::umc_pins_t pes;
    nxt_st   = st_ff;
    enc      = 1'b0;
    raw      = 1'b0;
    pulse_in = 1'b0;
    dec      = 1'b0;
    fall     = 1'b0;
    on       = st_ff.mode[umc_pkg::M_ON];
    infrared_enable     = st_ff.mode[umc_pkg::M_INFRARED_ENABLE];
    hs       = st_ff.mode[umc_pkg::M_HIGH_SPEED_SELECT];
    pes      = umc_pkg::umc_pins_t'(st_ff.mode[umc_pkg::M_PES +: 2]);
    op       = reg_addr[3:2];
    overrun_error_old = st_ff.sta[umc_pkg::S_OVERRUN_ERROR];
    run      = on & ~(st_ff.mode[umc_pkg::M_STOP_IN_IDLE] & cpu_idle);
    ticks    = hs ? umc_pkg::TICKS_4X : umc_pkg::TICKS_16X;
    pulse    = hs ? umc_pkg::IR_PULSE_4X : umc_pkg::IR_PULSE_16X;

    // Infrared encoder: short pulse at the start of each run of zero bits
    nxt_st.prev_tx = core_tx_bit;
    if (core_tx_bit != st_ff.prev_tx)
      nxt_st.enc_cnt = 5'd0;
    else if (baud_tick && st_ff.enc_cnt != ticks)
      nxt_st.enc_cnt = st_ff.enc_cnt + 5'd1;
    enc = ~core_tx_bit & (st_ff.enc_cnt < pulse);

    // Receive path: loopback, polarity, infrared decode
    raw      = st_ff.mode[umc_pkg::M_LPBK] ? st_ff.tx_o : rx_s;
    pulse_in = raw ^ st_ff.mode[umc_pkg::M_RECEIVE_INVERT];
    if (pulse_in)
      nxt_st.dec_cnt = ticks;
    else if (baud_tick && st_ff.dec_cnt != 5'd0)
      nxt_st.dec_cnt = st_ff.dec_cnt - 5'd1;
    dec = ~(pulse_in | (st_ff.dec_cnt != 5'd0));

    // Pin ownership follows enable, pin select and transmit enable
    nxt_st.run     = run;
    nxt_st.tx_oe   = on & st_ff.sta[umc_pkg::S_TXEN];
    nxt_st.tx_o    = (run ? (infrared_enable ? enc : core_tx_bit) : ~infrared_enable)
                     ^ st_ff.sta[umc_pkg::S_TXINV];
    nxt_st.rts_oe  = on & (pes == umc_pkg::UMC_PINS_RTS
                          || pes == umc_pkg::UMC_PINS_RTS_CTS);
    nxt_st.rts_o   = st_ff.mode[umc_pkg::M_RTS_MODE_SELECT] ? core_rts_simplex
                                                  : core_rts_flow;
    nxt_st.bclk_oe = on & (pes == umc_pkg::UMC_PINS_BCLK);
    if (baud_tick && run)
      nxt_st.bclk_o = ~st_ff.bclk_o;
    // Unused CTS reads as asserted so the transmitter is never stuck
    nxt_st.cts_n   = on & (pes == umc_pkg::UMC_PINS_RTS_CTS) & cts_s;
    nxt_st.rx_bit  = (on & st_ff.sta[umc_pkg::S_RXEN])
                     ? (infrared_enable ? dec : pulse_in) : 1'b1;

    // Wake on start bit while sleeping
    nxt_st.prev_rx = rx_lvl;
    fall           = st_ff.prev_rx & ~rx_lvl;
    nxt_st.wake    = on & cpu_sleep & st_ff.mode[umc_pkg::M_WAKE] & fall;

    // Read-only status flags track the core
    nxt_st.sta[umc_pkg::S_TXBF]  = core_tx_buffer_full;
    nxt_st.sta[umc_pkg::S_TX_SHIFT_EMPTY]  = core_tx_shift_empty;
    nxt_st.sta[umc_pkg::S_RECEIVER_IDLE] = core_receiver_idle;
    nxt_st.sta[umc_pkg::S_PARITY_ERROR]  = core_parity_error;
    nxt_st.sta[umc_pkg::S_FRAMING_ERROR]  = core_framing_error;
    nxt_st.sta[umc_pkg::S_RXDA]  = core_rx_data_available;
    if (core_break_done)
      nxt_st.sta[umc_pkg::S_BRK] = 1'b0;
    if (meas_done)
    begin
      nxt_st.mode[umc_pkg::M_AUTO_BAUD_ENABLE] = 1'b0;
      nxt_st.baud                   = meas_period;
    end
    nxt_st.flush = 1'b0;

    // Register writes, with aliases; software set beats hardware clear
    if (reg_wr && reg_addr[1:0] == 2'b00)
    begin
      if (reg_addr[7:4] == umc_pkg::BLK_MODE)
        nxt_st.mode = umc_pkg::umc_apply(nxt_st.mode, reg_wdata,
                                         umc_pkg::MODE_MASK, op);
      else if (reg_addr[7:4] == umc_pkg::BLK_STATUS)
      begin
        nxt_st.sta = umc_pkg::umc_apply(nxt_st.sta, reg_wdata,
                                        umc_pkg::STA_WMASK, op);
        // Overrun flag may only be cleared by software
        if ((op == umc_pkg::OP_WRITE && !reg_wdata[umc_pkg::S_OVERRUN_ERROR])
            || (op == umc_pkg::OP_CLR && reg_wdata[umc_pkg::S_OVERRUN_ERROR]))
        begin
          nxt_st.sta[umc_pkg::S_OVERRUN_ERROR] = 1'b0;
          nxt_st.flush                = overrun_error_old;
        end
      end
      else if (reg_addr == umc_pkg::OFS_IRQ_CLR)
        nxt_st.irq_st = st_ff.irq_st & ~reg_wdata[umc_pkg::IRQ_W-1:0];
      else if (reg_addr == umc_pkg::OFS_IRQ_EN)
        nxt_st.irq_en = reg_wdata[umc_pkg::IRQ_W-1:0];
    end
    // Hardware events win over a clear in the same cycle
    if (core_overrun)
      nxt_st.sta[umc_pkg::S_OVERRUN_ERROR] = 1'b1;
    if (nxt_st.wake)
      nxt_st.irq_st[umc_pkg::IRQ_WAKE] = 1'b1;
    if (meas_done)
      nxt_st.irq_st[umc_pkg::IRQ_BAUD] = 1'b1;
    if (core_overrun)
      nxt_st.irq_st[umc_pkg::IRQ_OVR] = 1'b1;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_en);

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd && reg_addr[1:0] == 2'b00)
    begin
      if (reg_addr[7:4] == umc_pkg::BLK_MODE && op == umc_pkg::OP_WRITE)
        nxt_st.rdata = st_ff.mode & umc_pkg::MODE_MASK;
      else if (reg_addr[7:4] == umc_pkg::BLK_STATUS && op == umc_pkg::OP_WRITE)
        nxt_st.rdata = st_ff.sta;
      else if (reg_addr == umc_pkg::OFS_IRQ_STAT)
        nxt_st.rdata = 32'(st_ff.irq_st);
      else if (reg_addr == umc_pkg::OFS_IRQ_EN)
        nxt_st.rdata = 32'(st_ff.irq_en);
      else if (reg_addr == umc_pkg::OFS_BAUD)
        nxt_st.rdata = 32'(st_ff.baud);
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_ff         <= '0;
      st_ff.mode    <= umc_pkg::MODE_RST;
      st_ff.sta     <= umc_pkg::STA_RST;
      st_ff.tx_o    <= 1'b1;
      st_ff.rx_bit  <= 1'b1;
      st_ff.prev_rx <= 1'b1;
      st_ff.prev_tx <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // Processed receive level for edge detection, from flops only
  assign rx_lvl = st_ff.rx_bit;

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata              = st_ff.rdata;
  assign irq                    = st_ff.irq;
  assign wake_req               = st_ff.wake;
  assign serial_out_pin_o       = st_ff.tx_o;
  assign serial_out_pin_oe      = st_ff.tx_oe;
  assign request_to_send_pin_o  = st_ff.rts_o;
  assign request_to_send_pin_oe = st_ff.rts_oe;
  assign baud_clock_out_pin_o   = st_ff.bclk_o;
  assign baud_clock_out_pin_oe  = st_ff.bclk_oe;
  assign core_run               = st_ff.run;
  assign core_rx_bit            = st_ff.rx_bit;
  assign core_cts_n             = st_ff.cts_n;
  assign core_rx_flush          = st_ff.flush;
  assign cfg_high_speed         = st_ff.mode[umc_pkg::M_HIGH_SPEED_SELECT];
  assign cfg_format             = st_ff.mode[umc_pkg::M_FMT +: 2];
  assign cfg_two_stop           = st_ff.mode[umc_pkg::M_STOP];
  assign cfg_status             = st_ff.sta;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_mode_reserved_zero: assert property (
    reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:16] == 16'h0000
      && reg_rdata[14] == 1'b0 && reg_rdata[10] == 1'b0)
    else $error("reserved mode bits read nonzero");

  chk_pins_released: assert property (
    !st_ff.mode[umc_pkg::M_ON] |=> !serial_out_pin_oe
      && !request_to_send_pin_oe && !baud_clock_out_pin_oe)
    else $error("pins driven while disabled");

  chk_idle_halt: assert property (
    st_ff.mode[umc_pkg::M_STOP_IN_IDLE] && cpu_idle |=> !core_run)
    else $error("module runs during idle");

  chk_rx_polarity: assert property (
    st_ff.mode[umc_pkg::M_ON] && st_ff.sta[umc_pkg::S_RXEN]
      && !st_ff.mode[umc_pkg::M_INFRARED_ENABLE] && !st_ff.mode[umc_pkg::M_LPBK]
      |=> core_rx_bit == ($past(rx_s) ^ $past(st_ff.mode[umc_pkg::M_RECEIVE_INVERT])))
    else $error("receive polarity wrong");

  chk_loopback_path: assert property (
    st_ff.mode[umc_pkg::M_ON] && st_ff.sta[umc_pkg::S_RXEN]
      && !st_ff.mode[umc_pkg::M_INFRARED_ENABLE] && st_ff.mode[umc_pkg::M_LPBK]
      |=> core_rx_bit == ($past(st_ff.tx_o) ^ $past(st_ff.mode[umc_pkg::M_RECEIVE_INVERT])))
    else $error("loopback not routed");

  chk_bclk_select: assert property (
    st_ff.mode[umc_pkg::M_ON] && st_ff.mode[umc_pkg::M_PES +: 2] == 2'b11
      |=> baud_clock_out_pin_oe && !request_to_send_pin_oe)
    else $error("baud clock pin select wrong");

  chk_rts_mode: assert property (
    st_ff.mode[umc_pkg::M_RTS_MODE_SELECT] |=> request_to_send_pin_o == $past(core_rts_simplex))
    else $error("simplex rts not selected");

  chk_alias_set: assert property (
    reg_wr && reg_addr == 8'h08 |=> ((st_ff.mode & $past(reg_wdata)
      & umc_pkg::MODE_MASK) == ($past(reg_wdata) & umc_pkg::MODE_MASK)))
    else $error("set alias did not set");

  chk_auto_baud_enable_clear: assert property (
    meas_done && !reg_wr |=> !st_ff.mode[umc_pkg::M_AUTO_BAUD_ENABLE] ##1 !u_meter.done)
    else $error("auto baud not self-cleared");

  chk_wake_pulse: assert property (
    wake_req |-> $past(cpu_sleep) && $past(st_ff.mode[umc_pkg::M_WAKE]) ##1 !wake_req)
    else $error("wake without sleep and enable");

  chk_status_reset: assert property (
    $fell(rst) |-> st_ff.sta == umc_pkg::STA_RST && st_ff.mode == umc_pkg::MODE_RST)
    else $error("status reset value wrong");
endmodule

// ==== hdl/umc_pkg.sv ====
// Constants and helpers for the serial mode control block.
// Assumes a 32-bit register port with byte addresses and one clock domain.
package umc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [3:0] BLK_MODE     = 4'h0;
  localparam logic [3:0] BLK_STATUS   = 4'h1;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h28;
  localparam logic [7:0] OFS_BAUD     = 8'h30;
  localparam logic [1:0] OP_WRITE     = 2'h0;
  localparam logic [1:0] OP_CLR       = 2'h1;
  localparam logic [1:0] OP_SET       = 2'h2;
  localparam logic [1:0] OP_INV       = 2'h3;

  // ------------------------------------------------------------
  // Masks and reset values
  // ------------------------------------------------------------
  localparam logic [31:0] MODE_MASK   = 32'h0000_BBFF;
  localparam logic [31:0] MODE_RST    = 32'h0000_0000;
  localparam logic [31:0] STA_WMASK   = 32'h01FF_FCE0;
  localparam logic [31:0] STA_RST     = 32'h0000_0110;

  // ------------------------------------------------------------
  // Mode fields
  // ------------------------------------------------------------
  localparam int M_ON    = 15;
  localparam int M_STOP_IN_IDLE  = 13;
  localparam int M_INFRARED_ENABLE  = 12;
  localparam int M_RTS_MODE_SELECT = 11;
  localparam int M_PES   = 8;
  localparam int M_WAKE  = 7;
  localparam int M_LPBK  = 6;
  localparam int M_AUTO_BAUD_ENABLE = 5;
  localparam int M_RECEIVE_INVERT = 4;
  localparam int M_HIGH_SPEED_SELECT  = 3;
  localparam int M_FMT   = 1;
  localparam int M_STOP  = 0;

  // ------------------------------------------------------------
  // Status fields
  // ------------------------------------------------------------
  localparam int S_TXINV = 13;
  localparam int S_RXEN  = 12;
  localparam int S_BRK   = 11;
  localparam int S_TXEN  = 10;
  localparam int S_TXBF  = 9;
  localparam int S_TX_SHIFT_EMPTY  = 8;
  localparam int S_RECEIVER_IDLE = 4;
  localparam int S_PARITY_ERROR  = 3;
  localparam int S_FRAMING_ERROR  = 2;
  localparam int S_OVERRUN_ERROR  = 1;
  localparam int S_RXDA  = 0;

  // ------------------------------------------------------------
  // Interrupt bits and timing counts
  // ------------------------------------------------------------
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_WAKE      = 0;
  localparam int          IRQ_BAUD      = 1;
  localparam int          IRQ_OVR       = 2;
  localparam logic [4:0]  TICKS_16X     = 5'd16;
  localparam logic [4:0]  TICKS_4X      = 5'd4;
  localparam logic [4:0]  IR_PULSE_16X  = 5'd3;
  localparam logic [4:0]  IR_PULSE_4X   = 5'd1;
  localparam logic [2:0]  SYNC_EDGES    = 3'd4;
  localparam int          SYNC_BITS_LOG = 3;

  typedef enum logic [1:0] {
    UMC_PINS_TXRX    = 2'b00,
    UMC_PINS_RTS     = 2'b01,
    UMC_PINS_RTS_CTS = 2'b10,
    UMC_PINS_BCLK    = 2'b11
  } umc_pins_t;

  function automatic logic [31:0] umc_apply(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] mask,
    input logic [1:0]  op
  );
    logic [31:0] m;
    m = wd & mask;
    case (op)
      OP_WRITE: umc_apply = (old & ~mask) | m;
      OP_CLR:   umc_apply = old & ~m;
      OP_SET:   umc_apply = old | m;
      default:  umc_apply = old ^ m;
    endcase
  endfunction

endpackage

// ==== hdl/umc_sync.sv ====
// Two-stage synchroniser for pin levels.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module umc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } umc_sync_t;

  umc_sync_t st_ff;
  umc_sync_t nxt_st;

  // Idle pins read high until the first real sample
  always_comb
  begin
    nxt_st.meta = d;
    nxt_st.q    = st_ff.meta;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      st_ff <= '1;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.q;
endmodule

// ==== test/tb_top.sv ====
// Register-level testbench of the serial mode control block.
// Assumes the remote device model drives the receive pin.
`timescale 1ns/1ps
module tb_top;
  localparam int P = 40;
  logic        ref_clk, rst, reg_wr, reg_rd, cpu_idle, cpu_sleep, cts, tx_bit;
  logic        send, rx_line, inv, irq, wake_req, core_run, rx_bit, hs, two, rts_oe, bc_oe;
  logic        seen;
  logic        tx_oe, rts_o, cts_n;
  logic [1:0]  rts_in;
  logic [7:0]  reg_addr;
  logic [5:0]  flags;
  logic [1:0]  fmt;
  logic [31:0] reg_wdata, reg_rdata, rv;
  int          num_errors, num_checks;

  umc_remote_dev #(.BIT_CYC(P)) peer_u (.ref_clk(ref_clk), .send(send), .data(8'h55),
    .line(rx_line));
  umc_mode_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .wake_req(wake_req),
    .serial_in_pin(rx_line ^ inv), .clear_to_send_pin(cts), .serial_out_pin_o(),
    .serial_out_pin_oe(tx_oe), .request_to_send_pin_o(rts_o), .request_to_send_pin_oe(rts_oe),
    .baud_clock_out_pin_o(), .baud_clock_out_pin_oe(bc_oe), .baud_tick(1'b0),
    .core_tx_bit(tx_bit), .core_rts_flow(rts_in[1]), .core_rts_simplex(rts_in[0]),
    .core_tx_buffer_full(flags[5]), .core_tx_shift_empty(flags[4]),
    .core_receiver_idle(flags[3]), .core_parity_error(flags[2]),
    .core_framing_error(flags[1]), .core_rx_data_available(flags[0]),
    .core_overrun(1'b0), .core_break_done(1'b0), .core_run(core_run),
    .core_rx_bit(rx_bit), .core_cts_n(cts_n), .core_rx_flush(), .cfg_high_speed(hs),
    .cfg_format(fmt), .cfg_two_stop(two), .cfg_status());

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    {reg_wr, reg_rd, cpu_idle, cpu_sleep, send, inv} = 6'h00;
    {cts, tx_bit} = 2'b11;
    rts_in = 2'b00;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    flags = 6'b01_1000;
    rst = 1'b1;
    cyc(2);
    rst <= 1'b0;
    rd(8'h00); chk(rv, 32'h0000_0000, "mode reset");
    rd(8'h10); chk(rv, 32'h0000_0110, "status reset");
    flags <= 6'b10_0111;
    cyc(4);
    rd(8'h10); chk(rv, 32'h0000_020D, "status flags");
    flags <= 6'b01_1000;
    $display("test reset done");
    wr(8'h00, 32'hFFFF_FFFF); rd(8'h00); chk(rv, 32'h0000_BBFF, "reserved");
    wr(8'h04, 32'h0000_00FF); rd(8'h00); chk(rv, 32'h0000_BB00, "clr alias");
    wr(8'h08, 32'h0000_0001); rd(8'h00); chk(rv, 32'h0000_BB01, "set alias");
    wr(8'h0C, 32'hFFFF_FFDF); rd(8'h00); chk(rv, 32'h0000_00DE, "inv alias");
    rd(8'h04); chk(rv, 32'h0000_0000, "alias read");
    $display("test aliases done");
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h00, 32'(k)); cyc(2);
      chk({hs, fmt, two}, 32'(k), "format");
    end
    // Receiver and transmitter on, else the pins and rx path stay with the port
    wr(8'h10, 32'h0000_1400);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, 32'h0000_8000 | (32'(c) << 8)); cyc(2);
      // Expected drive per pin select, one nibble each
      chk({tx_oe, rts_oe, bc_oe, cts_n}, 4'(32'h0000_ADC8 >> (4 * c)), "pins");
    end
    wr(8'h00, 32'h0000_8900); rts_in <= 2'b01; cyc(2);
    chk(rts_o, 1, "simplex rts");
    wr(8'h00, 32'h0000_8100); rts_in <= 2'b10; cyc(2);
    chk(rts_o, 1, "flow rts");
    wr(8'h00, 32'h0000_0300); cyc(2);
    chk({tx_oe, rts_oe, bc_oe, core_run}, 0, "module off");
    $display("test pins done");
    wr(8'h00, 32'h0000_A000); cpu_idle <= 1'b1; cyc(3);
    chk(core_run, 0, "stop in idle");
    wr(8'h00, 32'h0000_8000); cyc(3);
    chk(core_run, 1, "run in idle");
    cpu_idle <= 1'b0;
    wr(8'h00, 32'h0000_8040); tx_bit <= 1'b0; cyc(5);
    chk(rx_bit, 0, "loopback");
    tx_bit <= 1'b1;
    wr(8'h00, 32'h0000_8010); inv <= 1'b1; cyc(5);
    chk(rx_bit, 1, "inverted idle");
    inv <= 1'b0; cyc(5);
    chk(rx_bit, 0, "inverted active");
    $display("test modes done");
    wr(8'h28, 32'h0000_0002); wr(8'h00, 32'h0000_8020);
    send <= 1'b1;
    for (int i = 0; i < 20 * P && irq !== 1'b1; i++) cyc(1);
    send <= 1'b0;
    chk(irq, 1, "baud irq");
    rd(8'h00); chk(rv[5], 0, "auto_baud_enable self clear");
    rd(8'h30); chk(rv >= P - 1 && rv <= P + 1, 1, "bit period");
    wr(8'h28, 32'h0000_0000); cyc(2); chk(irq, 0, "irq masked");
    wr(8'h28, 32'h0000_0002); cyc(2); chk(irq, 1, "irq unmasked");
    wr(8'h24, 32'h0000_0002); cyc(2); chk(irq, 0, "irq cleared");
    cyc(4 * P);
    $display("test auto baud done");
    wr(8'h00, 32'h0000_8080); cpu_sleep <= 1'b1; cyc(5);
    send <= 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 12 * P; i++)
    begin
      cyc(1);
      seen = seen | (wake_req === 1'b1);
    end
    chk(seen, 1, "wake on start");
    {send, cpu_sleep} <= 2'b00;
    $display("test wake done");
    print_verdict();
  end
endmodule

// ==== test/umc_remote_dev.sv ====
// Remote serial device model: sends one frame when asked.
// Assumes bit time is a whole number of ref_clk cycles.
`timescale 1ns/1ps
module umc_remote_dev #(
  parameter int BIT_CYC = 40
) (
  input  wire logic       ref_clk,
  input  wire logic       send,
  input  wire logic [7:0] data,
  output logic            line
);
  initial line = 1'b1;
  // ------------------------------------------------------------
  // Frame: start, eight bits lsb first, stop; idle high between
  // ------------------------------------------------------------
  always @(posedge send)
  begin
    for (int i = 0; i < 10; i++)
    begin
      line <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : data[i-1];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
  end
endmodule
